// File: rtl/vc2_trail_term.sv
`timescale 1ns/1ps
`include "vc2_tt_consts.svh"

module vc2_trail_term (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sec_pulse,
    input wire vc2_tt_pkg::vc_byte_t src_in,
    output vc2_tt_pkg::vc_byte_t src_out,
    input wire vc2_tt_pkg::vc_byte_t snk_in,
    output vc2_tt_pkg::perf_rpt_t rpt,
    output logic rpt_valid,
    output logic trace_mismatch_defect,
    output logic unequipped_defect
);

    // Next byte position, wrapping at the multiframe end
    function automatic logic [`POS_W-1:0] next_pos(input logic [`POS_W-1:0] p);
        next_pos = (p == `POS_W'(`MF_BYTES - 1)) ? `POS_V5 : p + `POS_W'(1);
    endfunction

    // Even-parity contribution of one byte to the two interleaved bits
    function automatic logic [1:0] bip2(input logic [7:0] d);
        bip2 = {d[7] ^ d[5] ^ d[3] ^ d[1], d[6] ^ d[4] ^ d[2] ^ d[0]};
    endfunction

    logic [1:0] ctrl_q;
    logic [7:0] tx_trace_q;
    logic [7:0] exp_trace_q;
    logic monitoring_state;
    logic uni;
    logic [`POS_W-1:0] src_idx_q;
    logic [`POS_W-1:0] spos;
    logic [1:0] src_bip_q;
    logic rei_pend_q;
    logic rei_tx;
    logic rdi_tx;
    logic [7:0] sbyte;
    vc2_tt_pkg::vc_byte_t src_out_q;
    logic [`POS_W-1:0] snk_idx_q;
    logic [`POS_W-1:0] kpos;
    logic [1:0] snk_bip_q;
    vc2_tt_pkg::mf_state_t mf_q;
    logic at_v5;
    logic near_err;
    logic far_err;
    logic trace_bad_q;
    logic unequip_q;
    logic rdi_q;
    logic far_rdi;
    logic [`PERF_CNT_W-1:0] nebc_q;
    logic [`PERF_CNT_W-1:0] febc_q;
    logic nds_q;
    logic fds_q;
    vc2_tt_pkg::perf_rpt_t rpt_q;
    logic rpt_valid_q;
    logic trace_bad_rpt_q;
    logic unequip_rpt_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic apb_setup;
    logic apb_wr;
    logic mapped;

    assign monitoring_state = ctrl_q[`CTRL_MONITOR];
    assign uni = ctrl_q[`CTRL_UNI];

    // ---------------- Register slave ----------------
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready_q && pwrite;
    assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_TX_TRACE) ||
        (paddr == `REG_EXP_TRACE) || (paddr == `REG_STATUS) ||
        (paddr == `REG_NEBC) || (paddr == `REG_FEBC) || (paddr == `REG_DS);

    // Provisioning; writes land only at the completing access edge
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= `CTRL_RST;
            tx_trace_q <= `TRACE_RST;
            exp_trace_q <= `TRACE_RST;
        end
        else if (apb_wr)
        begin
            if (paddr == `REG_CTRL)
                ctrl_q <= pwdata[1:0];
            if (paddr == `REG_TX_TRACE)
                tx_trace_q <= pwdata[7:0];
            if (paddr == `REG_EXP_TRACE)
                exp_trace_q <= pwdata[7:0];
        end
    end

    // Fixed one-wait answer: pready rises in the first access cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= apb_setup && !pready_q;
            pslverr_q <= apb_setup && !pready_q && !mapped;
            if (apb_setup && !pwrite)
            begin
                unique case (paddr)
                    `REG_CTRL: prdata_q <= {30'h0, ctrl_q};
                    `REG_TX_TRACE: prdata_q <= {24'h00_0000, tx_trace_q};
                    `REG_EXP_TRACE: prdata_q <= {24'h00_0000, exp_trace_q};
                    `REG_STATUS: prdata_q <= {28'h000_0000, rdi_q, unequip_q, trace_bad_q, mf_q};
                    `REG_NEBC: prdata_q <= {16'h0000, rpt_q.near_errored_block_count};
                    `REG_FEBC: prdata_q <= {16'h0000, rpt_q.far_errored_block_count};
                    `REG_DS: prdata_q <= {30'h0, rpt_q.far_defect_second,
                        rpt_q.near_defect_second};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------- Source direction ----------------
    // Position inside the multiframe; sof re-aligns at V5
    assign spos = src_in.sof ? `POS_V5 : src_idx_q;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            src_idx_q <= `POS_V5;
        else if (src_in.valid)
            src_idx_q <= next_pos(spos);
    end

    // Remote indications are silenced when no return path exists
    assign rei_tx = rei_pend_q && !uni;
    assign rdi_tx = (trace_bad_q || unequip_q) && !uni;

    // Overhead insertion; everything else, K4 and N2 included, passes through
    always_comb
    begin
        sbyte = src_in.data;
        if (spos == `POS_V5)
            sbyte = {src_bip_q, rei_tx, 1'b0, src_in.data[3:1], rdi_tx};
        else if (spos == `POS_J2)
            sbyte = tx_trace_q;
    end

    // Parity over the bytes actually sent, so the far end checks what left us
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            src_bip_q <= 2'h0;
        else if (src_in.valid)
            src_bip_q <= (spos == `POS_V5) ? bip2(sbyte) : src_bip_q ^ bip2(sbyte);
    end

    // Error pending until the next V5 goes out; a new error wins over the clear
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rei_pend_q <= 1'b0;
        else
            rei_pend_q <= near_err || (rei_pend_q && !(src_in.valid && spos == `POS_V5));
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            src_out_q <= '0;
        else
        begin
            src_out_q.valid <= src_in.valid;
            src_out_q.sof <= src_in.sof && src_in.valid;
            src_out_q.data <= src_in.valid ? sbyte : 8'h00;
        end
    end

    // ---------------- Sink direction ----------------
    assign kpos = snk_in.sof ? `POS_V5 : snk_idx_q;
    assign at_v5 = snk_in.valid && kpos == `POS_V5;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            snk_idx_q <= `POS_V5;
        else if (snk_in.valid)
            snk_idx_q <= next_pos(kpos);
    end

    // Parity is only trusted after one whole multiframe has been seen
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            mf_q <= vc2_tt_pkg::MF_HUNT;
        else if (snk_in.valid && snk_in.sof)
            mf_q <= vc2_tt_pkg::MF_SYNC;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            snk_bip_q <= 2'h0;
        else if (snk_in.valid)
            snk_bip_q <= at_v5 ? bip2(snk_in.data) : snk_bip_q ^ bip2(snk_in.data);
    end

    // Block verdicts; bit 4 of V5 is never looked at
    assign near_err = at_v5 && mf_q == vc2_tt_pkg::MF_SYNC &&
        snk_in.data[7:6] != snk_bip_q;
    assign far_err = at_v5 && snk_in.data[5] && !uni;
    assign far_rdi = rdi_q && !uni;

    // Defect levels follow the latest overhead seen
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trace_bad_q <= 1'b0;
            unequip_q <= 1'b0;
            rdi_q <= 1'b0;
        end
        else
        begin
            if (snk_in.valid && kpos == `POS_J2)
                trace_bad_q <= snk_in.data != exp_trace_q;
            if (at_v5)
            begin
                unequip_q <= snk_in.data[3:1] == `SL_UNEQUIPPED;
                rdi_q <= snk_in.data[0];
            end
        end
    end

    // Defect outputs rise only in monitoring state; the status register shows the levels in any state
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trace_bad_rpt_q <= 1'b0;
            unequip_rpt_q <= 1'b0;
        end
        else
        begin
            trace_bad_rpt_q <= monitoring_state && trace_bad_q;
            unequip_rpt_q <= monitoring_state && unequip_q;
        end
    end

    // One-second integration; an event in the boundary cycle opens the new second
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nebc_q <= '0;
            febc_q <= '0;
            nds_q <= 1'b0;
            fds_q <= 1'b0;
        end
        else if (sec_pulse)
        begin
            nebc_q <= `PERF_CNT_W'(near_err);
            febc_q <= `PERF_CNT_W'(far_err);
            nds_q <= trace_bad_q || unequip_q;
            fds_q <= far_rdi;
        end
        else
        begin
            nebc_q <= nebc_q + `PERF_CNT_W'(near_err);
            febc_q <= febc_q + `PERF_CNT_W'(far_err);
            nds_q <= nds_q || trace_bad_q || unequip_q;
            fds_q <= fds_q || far_rdi;
        end
    end

    // Report snapshot; outside monitoring state the last report is kept
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rpt_q <= '0;
            rpt_valid_q <= 1'b0;
        end
        else
        begin
            rpt_valid_q <= sec_pulse && monitoring_state;
            if (sec_pulse && monitoring_state)
                rpt_q <= '{nebc_q, febc_q, nds_q, fds_q};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign src_out = src_out_q;
    assign rpt = rpt_q;
    assign rpt_valid = rpt_valid_q;
    assign trace_mismatch_defect = trace_bad_rpt_q;
    assign unequipped_defect = unequip_rpt_q;

    // ---------------- Checks ----------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_setup;
        psel && !penable && !pready;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_one_wait: assert property (s_setup ##1 psel && penable |-> pready)
        else $error("pready not given in first access cycle");

    a_v5_uni_zero: assert property (uni && src_in.valid && spos == `POS_V5 |=>
        src_out.data[5] == 1'b0 && src_out.data[0] == 1'b0)
        else $error("remote bits sent in unidirectional mode");

    a_j2_trace: assert property (src_in.valid && !src_in.sof && src_idx_q == `POS_J2 |=>
        src_out.data == $past(tx_trace_q))
        else $error("J2 not replaced by transmit trace");

    a_label_pass: assert property (src_in.valid && spos == `POS_V5 |=>
        src_out.data[3:1] == $past(src_in.data[3:1]) && src_out.data[4] == 1'b0)
        else $error("signal label altered or bit 4 set");

    a_rei_sent: assert property (rei_pend_q && !uni && src_in.valid && spos == `POS_V5 |=>
        src_out.data[5])
        else $error("errored block not signalled back");

    a_nebc_count: assert property (near_err && !sec_pulse |=>
        nebc_q == $past(nebc_q) + `PERF_CNT_W'(1))
        else $error("near errored block not counted");

    a_far_idle: assert property (uni && !sec_pulse |=> febc_q == $past(febc_q) &&
        !(fds_q && !$past(fds_q)))
        else $error("far-end counting in unidirectional mode");

    a_rpt_sec: assert property (sec_pulse && monitoring_state |=> rpt_valid &&
        rpt.near_errored_block_count == $past(nebc_q))
        else $error("second report missing or wrong");

    a_rpt_quiet: assert property (!(sec_pulse && monitoring_state) |=> !rpt_valid)
        else $error("report outside a monitored boundary");

    a_trace_report: assert property (trace_bad_q && monitoring_state |=> trace_mismatch_defect)
        else $error("trace mismatch not reported");

    a_nds_mark: assert property ((trace_bad_q || unequip_q) && !sec_pulse |=> nds_q)
        else $error("defect second not marked");

endmodule

// File: rtl/vc2_tt_consts.svh
`ifndef VC2_TT_CONSTS_SVH
`define VC2_TT_CONSTS_SVH

// Multiframe geometry: payload plus overhead, four equal sub-frames
`define MF_PAYLOAD 424
`define MF_POH 4
`define MF_BYTES (`MF_PAYLOAD + `MF_POH)
`define POS_W 9
`define POS_V5 9'h000
`define POS_J2 9'h06B
`define SL_UNEQUIPPED 3'h0

// Performance counter width
`define PERF_CNT_W 16

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_TX_TRACE 8'h04
`define REG_EXP_TRACE 8'h08
`define REG_STATUS 8'h0C
`define REG_NEBC 8'h10
`define REG_FEBC 8'h14
`define REG_DS 8'h18

// Control fields and reset values
`define CTRL_MONITOR 0
`define CTRL_UNI 1
`define CTRL_RST 2'h0
`define TRACE_RST 8'h00

`endif

// File: rtl/vc2_tt_pkg.sv
`include "vc2_tt_consts.svh"

package vc2_tt_pkg;

    // One byte of the multiframe stream; sof marks the first overhead byte
    typedef struct packed {
        logic valid;
        logic sof;
        logic [7:0] data;
    } vc_byte_t;

    // One-second performance report
    typedef struct packed {
        logic [`PERF_CNT_W-1:0] near_errored_block_count;
        logic [`PERF_CNT_W-1:0] far_errored_block_count;
        logic near_defect_second;
        logic far_defect_second;
    } perf_rpt_t;

    typedef enum logic {
        MF_HUNT = 1'b0,
        MF_SYNC = 1'b1
    } mf_state_t;

endpackage

// File: tb/vc2_far_end.sv
`timescale 1ns/1ps
`include "vc2_tt_consts.svh"

// Far path end: sends back-to-back multiframes toward the sink port, never pausing
module vc2_far_end (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] tr,
    input wire logic [2:0] lbl,
    input wire logic rei,
    input wire logic rdi,
    input wire logic berr,
    output vc2_tt_pkg::vc_byte_t snk = '0,
    output logic [8:0] pos = 9'h000
);
    logic [8:0] np;
    logic [7:0] b;
    logic [1:0] bip;

    // Parity is run over exactly what went out, so a flipped bit shows in one frame only
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            snk <= '0;
            pos <= 9'(`MF_BYTES - 1);
            bip <= 2'b00;
        end
        else
        begin
            np = (pos == 9'(`MF_BYTES - 1)) ? 9'h000 : pos + 9'h001;
            b = 8'($urandom);
            if (np == `POS_V5)
                b = {bip ^ {berr, 1'b0}, rei, b[4], lbl, rdi};
            if (np == `POS_J2)
                b = tr;
            bip <= ((np == `POS_V5) ? 2'b00 : bip) ^ {^(b & 8'hAA), ^(b & 8'h55)};
            snk <= {1'b1, np == `POS_V5, b};
            pos <= np;
        end
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "vc2_tt_consts.svh"

module testbench;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sec_pulse = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, rpt_valid, trace_mismatch_defect, unequipped_defect;
    vc2_tt_pkg::vc_byte_t src_in = '0, src_out, snk_in;
    vc2_tt_pkg::perf_rpt_t rpt;
    logic [8:0] pos;
    logic [7:0] tr = 8'h3C, tx = 8'h00, exp_tr = 8'h3C, b, e, m;
    logic [2:0] lbl = 3'h1;
    logic rei = 0, rdi = 0, berr = 0, watch = 0, uni = 0, nds = 0, fds = 0, xnds, xfds;
    logic [1:0] obip = 0;
    logic [7:0] eq[$];
    int miscompares = 0, n_tests = 0, cyc = 0, ne = 0, fe = 0, xne, xfe;
    int nfr = 0, ofr = 0, sp = -1;

    always #2 sys_clk = ~sys_clk;

    vc2_trail_term i_dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sec_pulse, .src_in, .src_out, .snk_in, .rpt,
        .rpt_valid, .trace_mismatch_defect, .unequipped_defect);
    vc2_far_end i_far (.sys_clk, .rstn, .tr, .lbl, .rei, .rdi, .berr, .snk(snk_in), .pos);

    function automatic logic [1:0] par2(input logic [7:0] v);
        return {^(v & 8'hAA), ^(v & 8'h55)};
    endfunction

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] ex);
        n_tests++;
        if (seen !== ex)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // A hung handshake must still reach the verdict
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // Source stream, its reference, and the sink-side counting model
    always @(posedge sys_clk)
    begin
        if (rstn)
        begin
            if (src_out.valid)
            begin
                if (src_out.sof && ofr > 0)
                    chk("bip2 out", src_out.data[7:6], obip);
                if (src_out.sof)
                begin
                    ofr++;
                    obip = 2'b00;
                end
                obip ^= par2(src_out.data);
                m = src_out.sof ? 8'h3F : 8'hFF;
                chk("src_out", src_out.data & m, eq.pop_front() & m);
            end
            // Source frames start mid-way through sink frames so sink state is settled
            if (pos == 9'd198)
                sp = 0;
            else if (sp >= 0)
                sp = (sp + 1) % `MF_BYTES;
            if (sp >= 0)
            begin
                b = 8'($urandom);
                e = b;
                if (sp == 0)
                begin
                    b[3:1] = 3'h1;
                    e = {2'b00, !uni && berr && nfr > 1, 1'b0, 3'h1,
                        !uni && (tr != exp_tr || lbl == 3'h0)};
                end
                if (sp == `POS_J2)
                    e = tx;
                src_in <= {1'b1, sp == 0, b};
                eq.push_back(e);
            end
            if (snk_in.valid && pos == `POS_V5)
            begin
                nfr++;
                ne += int'(berr && nfr > 1);
                fe += int'(!uni && rei);
                fds |= !uni && rdi;
                nds |= tr != exp_tr || lbl == 3'h0;
            end
            if (pos == 9'd250 && nfr > 0)
            begin
                chk("trace defect", trace_mismatch_defect, watch && tr != exp_tr);
                chk("unequipped", unequipped_defect, watch && lbl == 3'h0);
            end
        end
    end

    // Registers first, then one-second intervals of three frames each
    initial
    begin
        void'($urandom(5));
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int a = 0; a < 7; a++)
        begin
            apb(1'b0, 8'(a * 4), 32'h0000_0000);
            chk("reset value", rd, 34'(a == 3));
        end
        apb(1'b1, `REG_NEBC, 32'h0000_FFFF);
        apb(1'b0, `REG_NEBC, 32'h0000_0000);
        chk("read only", rd, 34'h0);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped", {rd, er}, 34'h1);
        tx = 8'($urandom);
        apb(1'b1, `REG_TX_TRACE, {24'h0, tx});
        apb(1'b1, `REG_EXP_TRACE, {24'h0, exp_tr});
        apb(1'b0, `REG_TX_TRACE, 32'h0000_0000);
        chk("tx trace", rd, {26'h0, tx});
        $display("register tests done");
        apb(1'b1, `REG_CTRL, 32'h0000_0001);
        watch = 1'b1;
        for (int s = 0; s < 9; s++)
        begin
            @(posedge sys_clk iff pos == 9'd300);
            sec_pulse <= 1'b1;
            {xne, xfe, xnds, xfds} = {ne, fe, nds, fds};
            {ne, fe, nds, fds} = '0;
            @(posedge sys_clk);
            sec_pulse <= 1'b0;
            @(negedge sys_clk);
            if (s > 0)
            begin
                chk("rpt_valid", rpt_valid, watch);
                if (watch)
                    chk("report", rpt, {16'(xne), 16'(xfe), xnds, xfds});
                if (watch)
                    apb(1'b0, `REG_NEBC, 32'h0000_0000);
                if (watch)
                    chk("nebc reg", rd, 34'(16'(xne)));
            end
            $display("second %0d done", s);
            watch = (s != 3);
            uni = (s >= 5);
            apb(1'b1, `REG_CTRL, {30'h0, uni, watch});
            @(posedge sys_clk iff pos == 9'd300);
            berr <= (s == 1) | 1'($urandom);
            rei <= (s == 1) | 1'($urandom);
            rdi <= (s == 1) | 1'($urandom);
            lbl <= 1'($urandom) ? 3'h0 : 3'h1;
            tr <= 1'($urandom) ? exp_tr : 8'($urandom);
            @(posedge sys_clk iff pos == 9'd300);
            {berr, rei, rdi} <= 3'b000;
            lbl <= 3'h1;
            tr <= exp_tr;
        end
        finish_test();
    end
endmodule
